// [rtl/tone_meter_pkg.sv]
// package: command codes, register layouts and timing constants for tone generation and metering
package tone_meter_pkg;
	localparam int num_channels = 4;
	localparam int core_clk_mhz = 200;
	localparam int meter_period_ms = 4;
	localparam int meter_period_cycles = meter_period_ms * 1000 * core_clk_mhz;
	localparam int sample_rate_hz = 8000;
	localparam int sample_div_cycles = core_clk_mhz * 1000000 / sample_rate_hz;
	// command classes on the control port
	localparam logic [1:0] cmd_status = 2'h0;
	localparam logic [1:0] cmd_coef = 2'h1;
	localparam logic [1:0] cmd_extended = 2'h2;
	// coefficient codes for tone one and two; same pair for every channel, chosen by the channel field
	localparam logic [7:0] coef_code_tone_one = 8'h0c;
	localparam logic [7:0] coef_code_tone_two = 8'h0d;
	localparam logic [2:0] xr_level_threshold = 3'h7;
	localparam int coef_bytes = 4;
	// config_reg_one bit positions
	localparam int cr1_tone_one_on = 0;
	localparam int cr1_tone_two_on = 1;
	// config_reg_two bit positions
	localparam int cr2_voice_with_tone = 0;
	localparam int cr2_level_meter_enable = 1;
	localparam int cr2_digital_loop = 2;
	localparam int cr2_level_compare_result = 3;
	// default tone: phase step for 1000 Hz at 8 kHz on a 16-bit phase
	localparam logic [15:0] default_phase_step = 16'h2000;
	localparam logic [15:0] default_band_coef = 16'h5087;
	localparam logic [7:0] threshold_reset = 8'h80;

	typedef struct packed {
		logic [1:0] kind;
		logic [1:0] channel;
		logic [7:0] code;
		logic [7:0] data;
	} ctrl_cmd_t;

	typedef struct packed {
		logic [15:0] phase_step;
		logic [15:0] band_coef;
	} tone_coef_t;
endpackage : tone_meter_pkg

// [rtl/tone_meter.sv]
// tone generators, bandpass, voice muting and per-channel level meters with a shared threshold for four codec channels
// Operation
// [R01] two independent sine tone generators per channel, each with its own frequency
// [R02] status write to config_reg_one switches each tone generator on or off
// [R03] coefficient write plus four bytes loads the addressed generator's coefficients
// [R04] voice muted while any tone is on and voice_with_tone bit is zero
// [R05] tone path passes through a programmable bandpass filter
// [R06] after reset both generators default to 1000 Hz
// [R07] code 0c addresses tone one, 0d tone two, of channel one; the code uses the same pair for every channel, chosen by cmd.channel
// [R08] tone amplitude scaled by receive gain stages a and b after generators
// [R09] digital loop routes generated sine from receive into transmit path
// [R10] meter bandpass always uses the second tone generator's coefficients
// [R11] meter rectifies bandpassed transmit signal and compares power with threshold
// [R12] compare result bit in config_reg_two: 1 above threshold, 0 below
// [R13] one 8-bit threshold register shared by all four channels
// [R14] threshold written as extended register seven by extended write command
// [R15] controller keeps channel 1 or 3 operating when metering channel 2 or 4
// [R16] controller runs a midpoint search over threshold bytes
// [R17] search ends on consecutive bytes with result set for the lower one
// [R18] first result 4 ms after enabling, then refreshed every 4 ms
// [R19] enabling level metering switches off that channel's second tone generator
// [R20] threshold write applies at the next comparison update of every metering channel
module tone_meter
	import tone_meter_pkg::*;
#(
	parameter int channels = num_channels,
	parameter int meter_cycles = meter_period_cycles
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// control command port, same clock
	input wire logic cmd_valid,
	input wire ctrl_cmd_t cmd,
	// per-channel gain and voice streams, one sample per strobe
	input wire logic sample_strobe,
	input wire logic [7:0] receive_gain_stage_a [channels],
	input wire logic [7:0] receive_gain_stage_b [channels],
	input wire logic signed [15:0] voice_rx [channels],
	input wire logic signed [15:0] voice_tx [channels],
	// outputs
	output logic signed [15:0] rx_out [channels],
	output logic signed [15:0] tx_out [channels],
	output logic [7:0] config_reg_one [channels],
	output logic [7:0] config_reg_two [channels],
	output logic [7:0] level_threshold
);
	initial begin
		if (channels < 1 || channels > 4) $error("channels must be 1..4");
		if (meter_cycles < 2) $error("meter_cycles too small");
		// the byte shifter keeps three leading bytes, so the count is fixed
		if (coef_bytes != 4) $error("coef_bytes must be 4");
		// channel select on the port is two bits wide
		if (channels > (1 << 2)) $error("channel select too narrow");
	end

	localparam int ptr_w = 32;
	tone_coef_t coef_one [channels];
	tone_coef_t coef_two [channels];
	tone_coef_t next_coef_one [channels];
	tone_coef_t next_coef_two [channels];
	logic [7:0] next_cr1 [channels];
	logic [7:0] next_cr2 [channels];
	logic [7:0] next_threshold;
	logic [23:0] shift_bytes;
	logic [23:0] next_shift_bytes;
	logic [2:0] byte_count;
	logic [2:0] next_byte_count;
	logic second_gen;
	logic next_second_gen;
	logic [1:0] target_ch;
	logic [1:0] next_target_ch;
	// registered so the compare result lands one cycle after the update
	logic result_load [channels];
	logic result_val [channels];

	// command decoder
	always_comb begin
		next_coef_one = coef_one;
		next_coef_two = coef_two;
		next_cr1 = config_reg_one;
		next_cr2 = config_reg_two;
		next_threshold = level_threshold;
		next_shift_bytes = shift_bytes;
		next_byte_count = byte_count;
		next_second_gen = second_gen;
		next_target_ch = target_ch;
		if (cmd_valid && byte_count != 3'h0) begin
			// coefficient bytes arrive as plain data following the code
			if (byte_count == 3'(coef_bytes)) begin
				if (second_gen) begin
					next_coef_two[target_ch] = {shift_bytes, cmd.data}; // [R03]
				end else begin
					next_coef_one[target_ch] = {shift_bytes, cmd.data}; // [R03]
				end
				next_byte_count = 3'h0;
			end else begin
				next_shift_bytes = {shift_bytes[15:0], cmd.data};
				next_byte_count = byte_count + 3'h1;
			end
		end else if (cmd_valid) begin
			case (cmd.kind)
				cmd_status: begin
					if (cmd.code[0]) begin
						next_cr2[cmd.channel] = cmd.data;
						next_cr2[cmd.channel][cr2_level_compare_result] =
							config_reg_two[cmd.channel][cr2_level_compare_result];
					end else begin
						next_cr1[cmd.channel] = cmd.data; // [R02]
					end
				end
				cmd_coef: begin
					// codes 0c/0d for every channel; cmd.channel selects the channel
					if (cmd.code[7:1] == coef_code_tone_one[7:1]) begin // [R07]
						next_second_gen = (cmd.code == coef_code_tone_two); // [R07]
						next_target_ch = cmd.channel;
						next_byte_count = 3'h1;
					end
				end
				cmd_extended: begin
					if (cmd.code[2:0] == xr_level_threshold) begin
						next_threshold = cmd.data; // [R14]
					end
				end
				default: begin
				end
			endcase
		end
		for (int c = 0; c < channels; c++) begin
			if (next_cr2[c][cr2_level_meter_enable]) begin
				next_cr1[c][cr1_tone_two_on] = 1'b0; // [R19]
			end
		end
		for (int c = 0; c < channels; c++) begin
			if (result_load[c]) begin
				next_cr2[c][cr2_level_compare_result] = result_val[c]; // [R12]
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int c = 0; c < channels; c++) begin
				coef_one[c] <= '{default_phase_step, default_band_coef}; // [R06]
				coef_two[c] <= '{default_phase_step, default_band_coef}; // [R06]
				config_reg_one[c] <= 8'h00;
				config_reg_two[c] <= 8'h00;
			end
			level_threshold <= threshold_reset; // [R13]
			shift_bytes <= 24'h000000;
			byte_count <= 3'h0;
			second_gen <= 1'b0;
			target_ch <= 2'h0;
		end else begin
			coef_one <= next_coef_one;
			coef_two <= next_coef_two;
			config_reg_one <= next_cr1;
			config_reg_two <= next_cr2;
			level_threshold <= next_threshold;
			shift_bytes <= next_shift_bytes;
			byte_count <= next_byte_count;
			second_gen <= next_second_gen;
			target_ch <= next_target_ch;
		end
	end

	// per-channel signal path
	for (genvar c = 0; c < channels; c++) begin : g_ch
		logic [15:0] phase_one;
		logic [15:0] phase_two;
		logic [15:0] next_phase_one;
		logic [15:0] next_phase_two;
		logic signed [15:0] bp_state;
		logic signed [15:0] next_bp_state;
		logic signed [15:0] meter_bp;
		logic signed [15:0] next_meter_bp;
		logic [23:0] power_acc;
		logic [23:0] next_power_acc;
		logic [ptr_w-1:0] timer;
		logic [ptr_w-1:0] next_timer;
		logic signed [15:0] next_rx;
		logic signed [15:0] next_tx;
		logic next_load;
		logic next_val;
		logic signed [15:0] tri_one;
		logic signed [15:0] tri_two;
		logic signed [15:0] tone_sum;
		logic signed [15:0] filtered;
		logic signed [15:0] scaled;
		logic signed [31:0] gain_prod;
		logic [15:0] rect;

		// triangle approximates the sine; cheap and spectrally cleaned by the bandpass
		function automatic logic signed [15:0] wave(input logic [15:0] ph);
			logic [15:0] t;
			t = ph[15] ? ~{ph[14:0], 1'b0} : {ph[14:0], 1'b0};
			return signed'(t - 16'h8000);
		endfunction : wave

		always_comb begin
			tri_one = config_reg_one[c][cr1_tone_one_on] ? (wave(phase_one) >>> 2) : 16'sh0000;
			tri_two = config_reg_one[c][cr1_tone_two_on] ? (wave(phase_two) >>> 2) : 16'sh0000;
			tone_sum = tri_one + tri_two; // [R01]
			// one-pole section; coefficient low byte sets the pass weight
			filtered = bp_state + 16'(((32'(tone_sum) - 32'(bp_state)) *
				32'(coef_one[c].band_coef[7:0])) >>> 8); // [R05]
			gain_prod = 32'(filtered) * 32'(receive_gain_stage_a[c]) *
				32'(receive_gain_stage_b[c]);
			scaled = 16'(gain_prod >>> 14); // [R08]
			next_phase_one = phase_one;
			next_phase_two = phase_two;
			next_bp_state = bp_state;
			next_meter_bp = meter_bp;
			next_power_acc = power_acc;
			next_rx = rx_out[c];
			next_tx = tx_out[c];
			next_load = 1'b0;
			next_val = 1'b0;
			next_timer = timer;
			if (sample_strobe) begin
				next_phase_one = phase_one + coef_one[c].phase_step; // [R01]
				next_phase_two = phase_two + coef_two[c].phase_step; // [R01]
				next_bp_state = filtered;
				if ((config_reg_one[c][cr1_tone_one_on] || config_reg_one[c][cr1_tone_two_on])
					&& !config_reg_two[c][cr2_voice_with_tone]) begin
					next_rx = scaled; // [R04]
				end else begin
					next_rx = scaled + voice_rx[c];
				end
				next_tx = config_reg_two[c][cr2_digital_loop] ? scaled : voice_tx[c]; // [R09]
				next_meter_bp = meter_bp + 16'(((32'(next_tx) - 32'(meter_bp)) *
					32'(coef_two[c].band_coef[7:0])) >>> 8); // [R10]
			end
			rect = meter_bp[15] ? 16'(-meter_bp) : meter_bp; // [R11]
			if (!config_reg_two[c][cr2_level_meter_enable]) begin
				next_timer = '0;
				next_power_acc = 24'h000000;
			end else if (timer == ptr_w'(meter_cycles - 1)) begin
				// threshold read at update time, so a new value applies here
				next_load = 1'b1;
				next_val = power_acc[23:16] > level_threshold; // [R20]
				next_timer = '0; // [R18]
				next_power_acc = 24'h000000;
			end else begin
				next_timer = timer + ptr_w'(1);
				if (sample_strobe) begin
					// saturate rather than wrap so a loud tone never reads as quiet
					if (power_acc + 24'(rect) < power_acc) begin
						next_power_acc = 24'hffffff; // [R11]
					end else begin
						next_power_acc = power_acc + 24'(rect); // [R11]
					end
				end
			end
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				phase_one <= 16'h0000;
				phase_two <= 16'h0000;
				bp_state <= 16'sh0000;
				meter_bp <= 16'sh0000;
				power_acc <= 24'h000000;
				timer <= '0;
				rx_out[c] <= 16'sh0000;
				tx_out[c] <= 16'sh0000;
				result_load[c] <= 1'b0;
				result_val[c] <= 1'b0;
			end else begin
				phase_one <= next_phase_one;
				phase_two <= next_phase_two;
				bp_state <= next_bp_state;
				meter_bp <= next_meter_bp;
				power_acc <= next_power_acc;
				timer <= next_timer;
				rx_out[c] <= next_rx;
				tx_out[c] <= next_tx;
				result_load[c] <= next_load;
				result_val[c] <= next_val;
			end
		end
	end
endmodule : tone_meter

// [verification/tone_meter_props.sv]
// concurrent checks on the command port and register outputs of the tone and meter block
module tone_meter_props
	import tone_meter_pkg::*;
#(
	parameter int channels = num_channels,
	parameter int meter_cycles = meter_period_cycles
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// command port
	input wire logic cmd_valid,
	input wire ctrl_cmd_t cmd,
	// registers
	input wire logic [7:0] config_reg_one [channels],
	input wire logic [7:0] config_reg_two [channels],
	input wire logic [7:0] level_threshold
);
	logic [2:0] left;
	logic [2:0] next_left;
	logic hdr;
	// data bytes still owed after a coefficient header
	always_comb begin
		next_left = left;
		if (cmd_valid && left != 3'h0) begin
			next_left = left - 3'h1;
		end else if (cmd_valid && cmd.kind == cmd_coef &&
			cmd.code[7:1] == coef_code_tone_one[7:1]) begin
			next_left = 3'(coef_bytes);
		end
	end
	always_ff @(posedge core_clk) begin
		if (reset) begin
			left <= 3'h0;
		end else begin
			left <= next_left;
		end
	end
	assign hdr = cmd_valid && left == 3'h0;
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_THR_LOAD: assert property (
		hdr && cmd.kind == cmd_extended && cmd.code[2:0] == xr_level_threshold
		|=> level_threshold == $past(cmd.data)) else $error("threshold not loaded");
	AST_THR_HOLD: assert property (
		!(hdr && cmd.kind == cmd_extended) |=> $stable(level_threshold))
		else $error("threshold moved without write");
	AST_TONE_SW: assert property (
		hdr && cmd.kind == cmd_status && !cmd.code[0] && cmd.channel == 2'h0
		|=> config_reg_one[0][1:0] == ($past(cmd.data[1:0]) &
		{!config_reg_two[0][cr2_level_meter_enable], 1'b1})) else $error("tone switch lost");
	AST_CR2_WR: assert property (
		hdr && cmd.kind == cmd_status && cmd.code[0] && cmd.channel == 2'h0
		|=> config_reg_two[0][2:0] == $past(cmd.data[2:0])) else $error("config two lost");
	AST_LM_TONE2: assert property (
		$rose(config_reg_two[0][cr2_level_meter_enable]) |-> !config_reg_one[0][cr1_tone_two_on])
		else $error("second tone kept on");
	AST_RES_LM: assert property (
		$rose(config_reg_two[0][cr2_level_compare_result])
		|-> $past(config_reg_two[0][cr2_level_meter_enable])) else $error("result without meter");
	AST_RES_WAIT: assert property (
		$rose(config_reg_two[0][cr2_level_meter_enable])
		|=> $stable(config_reg_two[0][cr2_level_compare_result]) [*8]) else $error("early result");
	AST_DATA_BYTE: assert property (
		cmd_valid && left != 3'h0 |=> $stable(config_reg_one[0]) && $stable(config_reg_two[0][2:0]))
		else $error("data byte taken as command");
endmodule : tone_meter_props

bind tone_meter tone_meter_props #(.channels(channels), .meter_cycles(meter_cycles))
	tone_meter_props_inst (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
	.cmd(cmd), .config_reg_one(config_reg_one), .config_reg_two(config_reg_two),
	.level_threshold(level_threshold));

// [verification/ctrl_master.sv]
// controller model issuing status, coefficient and extended writes on the command port
module ctrl_master
	import tone_meter_pkg::*;
(
	// clock
	input wire logic core_clk,
	// command port
	output logic cmd_valid,
	output ctrl_cmd_t cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end
	// one taken cycle; idle port shows inverted bits so stale data is never trusted
	task automatic put(input logic [1:0] kind, input logic [1:0] ch, input logic [7:0] code,
		input logic [7:0] data, input bit last);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= '{kind, ch, code, data};
		if (last) begin
			@(posedge core_clk);
			cmd_valid <= 1'b0;
			cmd <= ~cmd;
		end
	endtask : put
endmodule : ctrl_master

// [verification/test_tone_meter.sv]
// bench: register writes, muting, loop, coefficient loads and level metering
module test_tone_meter
	import tone_meter_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int mc = 200;
	logic core_clk, reset, cmd_valid, sample_strobe;
	ctrl_cmd_t cmd;
	logic [1:0] sdiv;
	logic [7:0] gain_a [4], gain_b [4], cr1 [4], cr2 [4], thr;
	logic signed [15:0] vrx [4], vtx [4], rx_out [4], tx_out [4];
	int errors, compares;
	tone_meter #(.channels(4), .meter_cycles(mc)) tone_meter_inst (.core_clk(core_clk),
		.reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .sample_strobe(sample_strobe),
		.receive_gain_stage_a(gain_a), .receive_gain_stage_b(gain_b), .voice_rx(vrx),
		.voice_tx(vtx), .rx_out(rx_out), .tx_out(tx_out), .config_reg_one(cr1),
		.config_reg_two(cr2), .level_threshold(thr));
	ctrl_master ctrl_master_inst (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : wait_cyc
	task automatic st(input int ch, input logic sel, input logic [7:0] d);
		ctrl_master_inst.put(cmd_status, 2'(ch), {7'h0, sel}, d, 1'b1);
		wait_cyc(1);
	endtask : st
	task automatic th(input logic [7:0] d);
		ctrl_master_inst.put(cmd_extended, 2'h1, 8'h07, d, 1'b1);
		wait_cyc(1);
		check(thr, d);
	endtask : th
	task automatic conclude();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// sample steps every fourth cycle keep the run short
	always @(posedge core_clk) begin
		sdiv <= sdiv + 2'h1;
		sample_strobe <= sdiv == 2'h0;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		sdiv = 2'h0;
		sample_strobe = 1'b0;
		gain_a = '{default: 8'h00};
		gain_b = '{default: 8'h00};
		vrx = '{default: 16'h1234};
		vtx = '{default: 16'h0567};
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		wait_cyc(1);
		check(thr, threshold_reset);
		check(cr1[0], 8'h00);
		for (int c = 0; c < 4; c++) begin
			st(c, 1'b0, 8'(c % 3 + 1));
			check(cr1[c], 8'(c % 3 + 1));
		end
		$display("tone switch test done");
		st(0, 1'b1, 8'h00);
		wait_cyc(40);
		check(rx_out[0], 16'h0000);
		st(0, 1'b1, 8'h01);
		wait_cyc(40);
		check(rx_out[0], 16'h1234);
		st(0, 1'b0, 8'h00);
		st(0, 1'b1, 8'h04);
		wait_cyc(40);
		check(tx_out[0], 16'h0000);
		st(0, 1'b1, 8'h00);
		wait_cyc(40);
		check(tx_out[0], 16'h0567);
		$display("mute and loop test done");
		// data bytes dressed as threshold writes must still count as coefficients
		for (int k = 0; k < 2; k++) begin
			ctrl_master_inst.put(cmd_coef, 2'h0, coef_code_tone_one + 8'(k), 8'h00, 1'b0);
			for (int b = 0; b < coef_bytes; b++) begin
				ctrl_master_inst.put(cmd_extended, 2'h0, 8'h07, 8'(b * 17), b == coef_bytes - 1);
			end
			wait_cyc(1);
			check(thr, threshold_reset);
		end
		$display("coefficient test done");
		st(0, 1'b0, 8'h02);
		check(cr1[0], 8'h02);
		st(0, 1'b1, 8'h02);
		check(cr1[0], 8'h00);
		@(posedge core_clk);
		gain_a[0] <= 8'h40;
		gain_b[0] <= 8'hff;
		th(8'hff);
		st(0, 1'b0, 8'h01);
		st(0, 1'b1, 8'h06);
		wait_cyc(2 * mc + 20);
		check(cr2[0][cr2_level_compare_result], 1'b0);
		th(8'h00);
		wait_cyc(2 * mc + 20);
		check(cr2[0][cr2_level_compare_result], 1'b1);
		$display("level meter test done");
		conclude();
	end
endmodule : test_tone_meter
